// ==== ext_voltage_adc_ctrl.sv ====
// Module: external voltage ADC sequencing and its registers
`timescale 1ns/1ps
module ext_voltage_adc_ctrl
    import ext_voltage_adc_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES,
    parameter int PER1 = PERIOD1_CYCLES,
    parameter int PER2 = PERIOD2_CYCLES,
    parameter int PER3 = PERIOD3_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire reg_req_s req,
    input wire power_mode_e power_mode,
    input wire logic [7:0] external_sense_input,
    output logic [7:0] rdata,
    output logic adc_irq,
    output logic power_irq,
    output logic conv_start
);
    typedef enum logic [1:0] {
        st_idle,
        st_conv
    } conv_state_e;

    logic go_q, go_d;
    logic [7:0] irq_en_q, irq_en_d;
    logic [7:0] result_q, result_d;
    logic [7:0] ref_q, ref_d;
    logic [7:0] delta_cfg_q, delta_cfg_d;
    logic [7:0] interval_cfg_q, interval_cfg_d;
    logic change_q, change_d;
    logic [7:0] rdata_q, rdata_d;
    logic adc_irq_q, adc_irq_d;
    logic power_irq_q, power_irq_d;
    logic conv_start_q, conv_start_d;
    conv_state_e state_q, state_d;
    logic single_q, single_d;
    logic [15:0] conv_cnt_q, conv_cnt_d;
    logic [15:0] per_cnt_q, per_cnt_d;

    logic [PERIOD_W-1:0] period_sel;
    logic [DELTA_W-1:0] delta_sel;
    logic bg_allowed;
    logic single_allowed;
    logic big_change;
    logic wr_start;
    logic wr_irq_en;
    logic wr_delta;
    logic wr_interval;
    logic wr_flags;
    logic start_single;
    logic start_bg;
    logic conv_last;
    logic report;

    function automatic logic [15:0] period_len(
        input logic [PERIOD_W-1:0] sel
    );
        case (sel)
            2'h1: period_len = 16'(PER1);
            2'h2: period_len = 16'(PER2);
            2'h3: period_len = 16'(PER3);
            default: period_len = 16'h0000;
        endcase
    endfunction : period_len

    function automatic logic [7:0] abs_diff(
        input logic [7:0] a,
        input logic [7:0] b
    );
        abs_diff = (a > b) ? a - b : b - a;
    endfunction : abs_diff

    // Register write strobe decode for one address
    function automatic logic write_hit(
        input reg_req_s r,
        input logic [7:0] a
    );
        write_hit = r.wr && (r.addr == a);
    endfunction : write_hit

    assign period_sel = interval_cfg_q[PERIOD_LSB +: PERIOD_W]; // [R04]
    assign delta_sel = delta_cfg_q[DELTA_LSB +: DELTA_W];
    // Mode gating of the two conversion sources
    assign bg_allowed = (power_mode == full_power_mode) // [R09]
        || (power_mode == sleep_monitor_mode); // [R10] [R11]
    assign single_allowed = (power_mode != sleep_monitor_mode); // [R11]
    assign big_change = abs_diff(external_sense_input, ref_q)
        > {5'h0_0, delta_sel}; // [R05]
    assign wr_start = write_hit(req, ADDR_START);
    assign wr_irq_en = write_hit(req, ADDR_IRQ_ENABLE);
    assign wr_delta = write_hit(req, ADDR_DELTA);
    assign wr_interval = write_hit(req, ADDR_INTERVAL);
    assign wr_flags = write_hit(req, ADDR_IRQ_FLAGS);
    // Single requests take priority over a due background tick
    assign start_single = (state_q == st_idle) && go_q // [R09] [R10]
        && single_allowed;
    assign start_bg = (state_q == st_idle) && !start_single // [R04] [R11]
        && (period_sel != '0) && bg_allowed
        && (per_cnt_q + 16'h0001 >= period_len(period_sel));
    assign conv_last = (state_q == st_conv)
        && (conv_cnt_q + 16'h0001 >= 16'(CONV_LEN));
    // Result and reference only move when an interrupt goes out
    assign report = conv_last && (single_q || big_change); // [R13]

    // Go bit: set by software, cleared when its conversion ends
    always_comb begin
        go_d = go_q;
        if (wr_start) begin
            go_d = req.wdata[GO_BIT]; // [R02]
        end
        // Completion wins against a same-cycle write
        if (conv_last && single_q) begin
            go_d = 1'b0; // [R15]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            go_q <= 1'b0;
        end else begin
            go_q <= go_d;
        end
    end

    // Interrupt enable byte
    always_comb begin
        irq_en_d = irq_en_q;
        if (wr_irq_en) begin
            irq_en_d = req.wdata; // [R07]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_en_q <= RESET_BYTE;
        end else begin
            irq_en_q <= irq_en_d;
        end
    end

    // Delta and interval configuration
    always_comb begin
        delta_cfg_d = delta_cfg_q;
        interval_cfg_d = interval_cfg_q;
        if (wr_delta) begin
            delta_cfg_d = req.wdata; // [R05]
        end
        if (wr_interval) begin
            interval_cfg_d = req.wdata; // [R04]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            delta_cfg_q <= RESET_BYTE;
            interval_cfg_q <= RESET_BYTE;
        end else begin
            delta_cfg_q <= delta_cfg_d;
            interval_cfg_q <= interval_cfg_d;
        end
    end

    // Change flag: write zero to clear, a hardware set wins a tie
    always_comb begin
        change_d = change_q;
        if (wr_flags && !req.wdata[CHANGE_BIT]) begin
            change_d = 1'b0;
        end
        if (conv_last && !single_q && big_change) begin
            change_d = 1'b1; // [R05] [R06]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            change_q <= 1'b0;
        end else begin
            change_q <= change_d;
        end
    end

    // Conversion sequencer and background interval counter
    always_comb begin
        state_d = state_q;
        single_d = single_q;
        conv_cnt_d = conv_cnt_q;
        per_cnt_d = per_cnt_q;
        // Interval zero keeps background off, including after reset
        if (period_sel == '0 || !bg_allowed) begin // [R03] [R10]
            per_cnt_d = '0;
        end else if (state_q == st_idle) begin
            per_cnt_d = per_cnt_q + 16'h0001;
        end
        case (state_q)
            st_idle: begin
                if (start_single) begin
                    state_d = st_conv;
                    single_d = 1'b1;
                    conv_cnt_d = '0;
                end else if (start_bg) begin
                    state_d = st_conv;
                    single_d = 1'b0;
                    conv_cnt_d = '0;
                    per_cnt_d = '0;
                end
            end
            st_conv: begin
                conv_cnt_d = conv_cnt_q + 16'h0001;
                if (conv_last) begin
                    state_d = st_idle;
                end
            end
            default: begin
                state_d = st_idle;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= st_idle;
            single_q <= 1'b0;
            conv_cnt_q <= '0;
            per_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            single_q <= single_d;
            conv_cnt_q <= conv_cnt_d;
            per_cnt_q <= per_cnt_d;
        end
    end

    // Result register, read-only to software
    always_comb begin
        result_d = result_q;
        if (report) begin
            result_d = external_sense_input; // [R12] [R01]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            result_q <= RESET_BYTE;
        end else begin
            result_q <= result_d;
        end
    end

    // Reference for later delta comparisons
    always_comb begin
        ref_d = ref_q;
        if (report) begin
            ref_d = external_sense_input; // [R15]
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ref_q <= RESET_BYTE;
        end else begin
            ref_q <= ref_d;
        end
    end

    // One-cycle events and the level power request
    always_comb begin
        adc_irq_d = report; // [R13] [R02]
        conv_start_d = start_single || start_bg;
        power_irq_d = change_d && irq_en_d[CHANGE_BIT]; // [R07]
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            adc_irq_q <= 1'b0;
            conv_start_q <= 1'b0;
            power_irq_q <= 1'b0;
        end else begin
            adc_irq_q <= adc_irq_d;
            conv_start_q <= conv_start_d;
            power_irq_q <= power_irq_d;
        end
    end

    // Read mux; the ADC interrupt itself has no readable flag
    always_comb begin
        rdata_d = RESET_BYTE;
        if (req.rd) begin // [R14]
            case (req.addr)
                ADDR_START: rdata_d = {5'h0_0, go_q, 2'h0};
                ADDR_IRQ_ENABLE: rdata_d = irq_en_q;
                ADDR_RESULT: rdata_d = result_q; // [R01]
                ADDR_DELTA: rdata_d = delta_cfg_q;
                ADDR_IRQ_FLAGS: rdata_d = {4'h0, change_q, 3'h0}; // [R06]
                ADDR_INTERVAL: rdata_d = interval_cfg_q;
                default: rdata_d = RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_q <= RESET_BYTE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;
    assign adc_irq = adc_irq_q;
    assign power_irq = power_irq_q;
    assign conv_start = conv_start_q;
endmodule : ext_voltage_adc_ctrl

// ==== ext_voltage_adc_pkg.sv ====
// Package: register map, fields and timing for the external voltage ADC
// Overview of operation
// R01 - Conversion code lands in 8-bit read-only result
// R02 - Go bit 2 starts one conversion
// R03 - Background conversions off until interval nonzero
// R04 - Background period from interval bits 5:4
// R05 - Change flag when delta exceeds bits 2:0
// R06 - Change condition shown in flag bit 3
// R07 - Enable bit 3 forwards flag as request
// R08 - Software: single, then delta, then interval
// R09 - Full power: single and background allowed
// R10 - Battery mode: single conversions only
// R11 - Sleep monitor mode: background conversions only
// R12 - Result loads only with an ADC interrupt
// R13 - Interrupt on big change or single done
// R14 - ADC interrupt has no status flag
// R15 - Reported code becomes reference; go self-clears
package ext_voltage_adc_pkg;
    localparam logic [7:0] ADDR_START = 8'h00_d8;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h00_ec;
    localparam logic [7:0] ADDR_RESULT = 8'h00_ef;
    localparam logic [7:0] ADDR_DELTA = 8'h00_f3;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h00_f8;
    localparam logic [7:0] ADDR_INTERVAL = 8'h00_f9;
    localparam int GO_BIT = 2;
    localparam int CHANGE_BIT = 3;
    localparam int DELTA_LSB = 0;
    localparam int DELTA_W = 3;
    localparam int PERIOD_LSB = 4;
    localparam int PERIOD_W = 2;
    localparam logic [7:0] RESET_BYTE = 8'h00_00;
    // Conversion time in ns, and cycles at the 10 ns clock
    localparam int CONV_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // Background interval lengths in cycles, per field code 1..3
    localparam int PERIOD1_CYCLES = 1000;
    localparam int PERIOD2_CYCLES = 2000;
    localparam int PERIOD3_CYCLES = 4000;

    typedef enum logic [1:0] {
        full_power_mode,
        battery_mode,
        sleep_monitor_mode
    } power_mode_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;
endpackage : ext_voltage_adc_pkg

// ==== ext_voltage_adc_ctrl_sva.sv ====
// Checker: port-level properties of the external voltage ADC control
`timescale 1ns/1ps
module ext_voltage_adc_ctrl_sva
    import ext_voltage_adc_pkg::*;
#(parameter int CONV_LEN = CONV_CYCLES) (
    input wire logic mclk,
    input wire logic rst,
    input wire reg_req_s req,
    input wire power_mode_e power_mode,
    input wire logic [7:0] external_sense_input,
    input wire logic [7:0] rdata,
    input wire logic adc_irq,
    input wire logic power_irq,
    input wire logic conv_start
);
    logic go_q, bg_q, en_q;
    logic [7:0] cnt_q;
    // Saturating age of the last conversion start
    always_ff @(posedge mclk) begin
        if (rst) begin
            go_q <= 1'b0;
            bg_q <= 1'b0;
            en_q <= 1'b0;
            cnt_q <= 8'hff;
        end else begin
            if (req.wr && req.addr == ADDR_START && req.wdata[GO_BIT])
                go_q <= 1'b1;
            else if (adc_irq)
                go_q <= 1'b0;
            if (req.wr && req.addr == ADDR_INTERVAL)
                bg_q <= |req.wdata[5:4];
            if (req.wr && req.addr == ADDR_IRQ_ENABLE)
                en_q <= req.wdata[CHANGE_BIT];
            cnt_q <= conv_start ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hff};
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_reset_quiet: assert property ($past(rst) |-> !adc_irq &&
        !conv_start &&
        !power_irq && rdata == 8'h00) else $error("outputs live in reset");
    a_read_idle: assert property (!$past(req.rd) |-> rdata == 8'h00)
        else $error("read data without read");
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start pulse too long");
    a_irq_pulse: assert property (adc_irq |=> !adc_irq)
        else $error("irq pulse too long");
    a_irq_timing: assert property (adc_irq |-> cnt_q >= CONV_LEN - 2 &&
        cnt_q <= CONV_LEN) else $error("irq not at conversion end");
    a_idle_quiet: assert property (!bg_q && !go_q |-> !conv_start)
        else $error("conversion with nothing enabled");
    a_battery_go: assert property ($past(power_mode) == battery_mode &&
        conv_start |-> go_q) else $error("background in battery mode");
    a_pirq_enable: assert property (power_irq |-> en_q)
        else $error("request while disabled");
    cover property (power_irq);
    cover property (power_mode == battery_mode && adc_irq);
    cover property (power_mode == sleep_monitor_mode && adc_irq);
endmodule : ext_voltage_adc_ctrl_sva

// ==== ext_sense_model.sv ====
// Partner: slow DC level on the external sense input
`timescale 1ns/1ps
module ext_sense_model (
    input wire logic mclk,
    input wire logic conv_start,
    input wire logic [7:0] level,
    output logic [7:0] external_sense_input
);
    initial external_sense_input = 8'h00;
    // Level only moves as a conversion begins
    always @(posedge mclk) begin
        if (conv_start)
            external_sense_input <= level;
    end
endmodule : ext_sense_model

// ==== ext_voltage_adc_ctrl_tb.sv ====
// Testbench: register-level scenarios for the external voltage ADC
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("ERROR %0t got %h want %h", $time, g, e); end end
module ext_voltage_adc_ctrl_tb;
    import ext_voltage_adc_pkg::*;
    localparam logic [7:0] ADDR_LIST [7] = '{ADDR_START, ADDR_IRQ_ENABLE,
        ADDR_RESULT, ADDR_DELTA, ADDR_IRQ_FLAGS, ADDR_INTERVAL, 8'hd0};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    reg_req_s req = '0;
    power_mode_e power_mode = full_power_mode;
    logic [7:0] level = 8'h00;
    logic [7:0] sense, rdata;
    logic adc_irq, power_irq, conv_start;
    int errors = 0;
    int checked = 0;
    always #5 mclk = ~mclk;
    ext_sense_model ext_sense_model_i (.mclk, .conv_start, .level,
        .external_sense_input(sense));
    ext_voltage_adc_ctrl #(.CONV_LEN(4), .PER1(20), .PER2(30), .PER3(40))
        ext_voltage_adc_ctrl_i (.mclk, .rst, .req, .power_mode,
        .external_sense_input(sense), .rdata, .adc_irq, .power_irq,
        .conv_start);
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) #1 req = '{1'b1, 1'b0, a, d};
        @(posedge mclk) #1 req = '0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk) #1 req = '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk) #1 req = '0;
        `CHK(rdata, e)
    endtask : rd
    task wait_irq(input int n, input logic e);
        logic got;
        got = 1'b0;
        for (int i = 0; i < n && !got; i++) @(posedge mclk) #1 got = adc_irq;
        `CHK(got, e)
    endtask : wait_irq
    task give_verdict;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    task t_reset_reads;
        foreach (ADDR_LIST[i]) rd(ADDR_LIST[i], 8'h00);
    endtask : t_reset_reads
    task t_single;
        level = 8'h5a;
        wr(ADDR_START, 8'h04);
        @(posedge mclk) #1 `CHK(conv_start, 1'b1)
        wait_irq(20, 1'b1);
        rd(ADDR_RESULT, 8'h5a);
        rd(ADDR_START, 8'h00);
        wr(ADDR_RESULT, 8'hff);
        rd(ADDR_RESULT, 8'h5a);
        rd(ADDR_IRQ_FLAGS, 8'h00);
    endtask : t_single
    task t_background;
        wr(ADDR_DELTA, 8'h02);
        wr(ADDR_IRQ_ENABLE, 8'h08);
        level = 8'h5c;
        wr(ADDR_INTERVAL, 8'h10);
        wait_irq(60, 1'b0);
        level = 8'h57;
        wait_irq(30, 1'b1);
        rd(ADDR_IRQ_FLAGS, 8'h08);
        rd(ADDR_RESULT, 8'h57);
        `CHK(power_irq, 1'b1)
        wr(ADDR_IRQ_FLAGS, 8'h00);
        rd(ADDR_IRQ_FLAGS, 8'h00);
        `CHK(power_irq, 1'b0)
    endtask : t_background
    task t_battery;
        power_mode = battery_mode;
        // Let a background conversion already under way finish first
        repeat (8) @(posedge mclk);
        #1 level = 8'h20;
        wait_irq(60, 1'b0);
        wr(ADDR_START, 8'h04);
        wait_irq(20, 1'b1);
        rd(ADDR_RESULT, 8'h20);
    endtask : t_battery
    task t_sleep;
        power_mode = sleep_monitor_mode;
        level = 8'h80;
        wait_irq(60, 1'b1);
        rd(ADDR_RESULT, 8'h80);
        wr(ADDR_INTERVAL, 8'h00);
        wr(ADDR_START, 8'h04);
        wait_irq(60, 1'b0);
    endtask : t_sleep
    initial begin
        repeat (5) @(posedge mclk);
        #1 rst = 1'b0;
        t_reset_reads;
        t_single;
        t_background;
        t_battery;
        t_sleep;
        give_verdict;
    end
    // Rough run is a few hundred cycles
    initial begin
        #100000;
        errors++;
        give_verdict;
    end
endmodule : ext_voltage_adc_ctrl_tb
bind ext_voltage_adc_ctrl ext_voltage_adc_ctrl_sva #(.CONV_LEN(CONV_LEN))
    ext_voltage_adc_ctrl_sva_i (.mclk, .rst, .req, .power_mode,
    .external_sense_input, .rdata, .adc_irq, .power_irq, .conv_start);
